// ===== src/isp_prog.sv
// serial in-system programming engine with code and data arrays
`timescale 1ns/100ps
`include "isp_defs.svh"

// What this block does
// - serial programming enabled as shipped
// - identity bytes read at 030H/031H, selects low
// - launched write completes on its own timer
// - enable instruction must precede program or erase
// - each write pre-erases its target byte
// - chip erase sets both arrays to FFH
// - code 0..1FFFH, data 0..7FFH, separate spaces
// - one byte per write, about 2.5 ms
// - read shifts addressed byte out on miso
// - reset pin low ends programming mode
// - every instruction is exactly three bytes
// - chip erase self-timed, about 16 ms
// - reads during chip erase return 00H
module isp_prog
	import isp_pkg::*;
#(
	parameter int         WRITE_CYCLES = `ISP_WRITE_TIME_NS / `ISP_CLK_PERIOD_NS,
	parameter int         ERASE_CYCLES = `ISP_ERASE_TIME_NS / `ISP_CLK_PERIOD_NS,
	parameter int         FIFO_DEPTH   = 8,
	parameter logic [7:0] SIG_BYTE0    = 8'h5C,  // arbitrary identity value
	parameter logic [7:0] SIG_BYTE1    = 8'h3D   // arbitrary identity value
)(
	// system clock
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// serial link
	input  wire logic spi_sck,
	input  wire logic spi_mosi,
	output logic      spi_miso,
	// device pins
	input  wire logic isp_reset_pin,
	input  wire logic signature_select_pin_a,
	input  wire logic signature_select_pin_b,
	// status
	output logic      prog_mode,
	output logic      isp_busy,
	output logic      cmd_overrun
);
	// counts must fit the timer and cover the erase sweep
	generate
		if (WRITE_CYCLES < 2 || ERASE_CYCLES <= 8192 || ERASE_CYCLES >= (1 << 24))
		begin : g_bad_counts
			$error("write or erase cycle count out of range");
		end
	endgenerate

	// classify the first two bytes of an instruction
	function automatic isp_op_t isp_decode(input logic [15:0] hdr);
		isp_op_t op;
		op = OP_NONE;
		if (hdr[15:8] == `ISP_OPC_ADMIN)
		begin
			if (hdr[7:0] == `ISP_KEY_ENABLE)
				op = OP_ENABLE;
			else if (hdr[7:0] == `ISP_KEY_ERASE)
				op = OP_ERASE;
		end
		else if (hdr[10:8] == `ISP_OP_RD_CODE)
			op = OP_RD_CODE;
		else if (hdr[10:8] == `ISP_OP_WR_CODE)
			op = OP_WR_CODE;
		else if (hdr[10:8] == `ISP_OP_RD_DATA && hdr[15:14] == 2'h0)
			op = OP_RD_DATA;
		else if (hdr[10:8] == `ISP_OP_WR_DATA && hdr[15:14] == 2'h0)
			op = OP_WR_DATA;
		return op;
	endfunction

	// link domain state
	logic [4:0]  bit_cnt_r;    // bits of current frame
	logic [22:0] rx_sh_r;      // incoming shift register
	logic [15:0] hdr_r;        // first two bytes, held
	logic [23:0] frame_r;      // whole frame, held
	logic        hdr_tgl_r;    // toggles when header complete
	logic        frame_tgl_r;  // toggles when frame complete
	logic [6:0]  tx_sh_r;      // outgoing bits
	logic        miso_r;       // miso pin flop
	// system domain state
	logic        link_clr_r;   // holds link logic idle
	logic [4:0]  sync1_r;      // first synchroniser stage
	logic [4:0]  sync2_r;      // second synchroniser stage
	logic [1:0]  tgl_s3_r;     // toggle history for edges
	logic [7:0]  rd_byte_r;    // byte for the link to send
	logic [23:0] pend_r;       // frame waiting for the fifo
	logic        pend_valid_r; // pend_r holds a frame
	logic        overrun_r;    // a frame was lost
	logic        prog_en_r;    // enable instruction seen
	logic        prog_mode_r;  // session active
	logic        busy_r;       // write or erase running
	isp_state_t  state_r;
	isp_state_t  state_nxt;
	logic [23:0] timer_r;
	logic [23:0] timer_nxt;
	logic [12:0] sweep_r;      // chip erase address
	logic        job_code_r;   // write targets code array
	logic [12:0] job_addr_r;
	logic [7:0]  job_data_r;
	// arrays
	logic [7:0]  code_mem [8192];
	logic [7:0]  data_mem [2048];

	// link input shifting on rising sck, msb first
	always_ff @(posedge spi_sck or posedge link_clr_r)
	begin
		if (link_clr_r)
		begin
			bit_cnt_r   <= '0;
			rx_sh_r     <= '0;
			hdr_r       <= '0;
			frame_r     <= '0;
			hdr_tgl_r   <= 1'b0;
			frame_tgl_r <= 1'b0;
		end
		else
		begin
			rx_sh_r <= {rx_sh_r[21:0], spi_mosi};
			bit_cnt_r <= (bit_cnt_r == `ISP_FRAME_LAST) ? 5'h00 : bit_cnt_r + 5'h01;
			if (bit_cnt_r == `ISP_HDR_LAST)
			begin
				hdr_r     <= {rx_sh_r[14:0], spi_mosi};
				hdr_tgl_r <= ~hdr_tgl_r;
			end
			if (bit_cnt_r == `ISP_FRAME_LAST)
			begin
				frame_r     <= {rx_sh_r, spi_mosi};
				frame_tgl_r <= ~frame_tgl_r;
			end
		end
	end

	// link output on falling sck; rd_byte_r is settled long before
	always_ff @(negedge spi_sck or posedge link_clr_r)
	begin
		if (link_clr_r)
		begin
			miso_r  <= 1'b0;
			tx_sh_r <= '0;
		end
		else if (bit_cnt_r == `ISP_DATA_FIRST)
		begin
			miso_r  <= rd_byte_r[7];
			tx_sh_r <= rd_byte_r[6:0];
		end
		else
		begin
			miso_r  <= tx_sh_r[6];
			tx_sh_r <= {tx_sh_r[5:0], 1'b0};
		end
	end
	assign spi_miso = miso_r;

	// pin and toggle synchronisers
	wire [4:0] async_in = {frame_tgl_r, hdr_tgl_r, signature_select_pin_b,
		signature_select_pin_a, isp_reset_pin};
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sync1_r  <= '0;
			sync2_r  <= '0;
			tgl_s3_r <= '0;
		end
		else if (clk_en)
		begin
			sync1_r  <= async_in;
			sync2_r  <= sync1_r;
			tgl_s3_r <= sync2_r[4:3];
		end
	end

	// decoded events and pin levels
	wire     session   = sync2_r[0];
	wire     sig_low   = ~sync2_r[1] & ~sync2_r[2];
	wire     hdr_evt   = clk_en & (sync2_r[3] ^ tgl_s3_r[0]);
	wire     frame_evt = clk_en & (sync2_r[4] ^ tgl_s3_r[1]);
	wire     erasing   = (state_r == S_CE_SWEEP) || (state_r == S_CE_WAIT);

	// read lookup from the held header
	isp_op_t     rd_op;
	assign rd_op = isp_decode(hdr_r);
	wire [12:0] rd_caddr = {hdr_r[15:11], hdr_r[7:0]};
	wire [10:0] rd_daddr = {hdr_r[13:11], hdr_r[7:0]};
	wire [7:0]  rd_code  = (sig_low && rd_caddr == `ISP_SIG_ADDR0) ? SIG_BYTE0 :
		(sig_low && rd_caddr == `ISP_SIG_ADDR1) ? SIG_BYTE1 : code_mem[rd_caddr];
	wire [7:0]  rd_val   = erasing ? `ISP_READ_BLANK :
		(rd_op == OP_RD_CODE) ? rd_code :
		(rd_op == OP_RD_DATA) ? data_mem[rd_daddr] : `ISP_READ_BLANK;

	// fifo between frame capture and sequencer
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [23:0] cmd;
	wire         pop = clk_en & fifo_out_valid & (state_r == S_IDLE);
	isp_fifo #(
		.WIDTH (`ISP_FRAME_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset | ~session),
		.in_valid  (pend_valid_r & clk_en),
		.in_ready  (fifo_in_ready),
		.in_data   (pend_r),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (cmd)
	);

	// command decode at the fifo head
	isp_op_t     op;
	assign op = isp_decode(cmd[23:8]);
	wire is_wr    = (op == OP_WR_CODE) || (op == OP_WR_DATA);
	wire start_wr = pop & prog_en_r & is_wr;
	wire start_ce = pop & prog_en_r & (op == OP_ERASE);
	wire do_en    = pop & (op == OP_ENABLE) & `ISP_FUSE_SHIPPED;
	wire lost     = frame_evt & pend_valid_r & ~fifo_in_ready;

	// session, capture and status flags
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			link_clr_r   <= 1'b1;
			rd_byte_r    <= '0;
			pend_r       <= '0;
			pend_valid_r <= 1'b0;
			overrun_r    <= 1'b0;
			prog_en_r    <= 1'b0;
			prog_mode_r  <= 1'b0;
			busy_r       <= 1'b0;
		end
		else if (clk_en)
		begin
			link_clr_r  <= ~session;
			prog_mode_r <= session;
			busy_r      <= (state_nxt != S_IDLE);
			if (hdr_evt)
				rd_byte_r <= rd_val;
			if (frame_evt)
				pend_r <= frame_r;
			pend_valid_r <= frame_evt | (pend_valid_r & ~fifo_in_ready);
			overrun_r <= lost | (overrun_r & session);
			prog_en_r <= session & (prog_en_r | do_en);
		end
	end

	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		case (state_r)
			S_IDLE:
			begin
				if (start_wr)
				begin
					state_nxt = S_WR_ERASE;
					timer_nxt = 24'(WRITE_CYCLES - 1);
				end
				else if (start_ce)
				begin
					state_nxt = S_CE_SWEEP;
					timer_nxt = 24'(ERASE_CYCLES - 1);
				end
			end
			S_WR_ERASE:
			begin
				state_nxt = S_WR_WAIT;
				timer_nxt = timer_r - 24'h000001;
			end
			S_WR_WAIT, S_CE_WAIT:
			begin
				if (timer_r == '0)
					state_nxt = S_IDLE;
				else
					timer_nxt = timer_r - 24'h000001;
			end
			S_CE_SWEEP:
			begin
				timer_nxt = timer_r - 24'h000001;
				if (sweep_r == `ISP_CODE_TOP)
					state_nxt = S_CE_WAIT;
			end
			default:
				state_nxt = S_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_r    <= S_IDLE;
			timer_r    <= '0;
			sweep_r    <= '0;
			job_code_r <= 1'b0;
			job_addr_r <= '0;
			job_data_r <= '0;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			sweep_r <= (state_r == S_CE_SWEEP) ? sweep_r + 13'h0001 : 13'h0000;
			if (start_wr)
			begin
				job_code_r <= (op == OP_WR_CODE);
				job_addr_r <= (op == OP_WR_CODE) ? {cmd[23:19], cmd[15:8]} :
					{2'h0, cmd[21:19], cmd[15:8]};
				job_data_r <= cmd[7:0];
			end
		end
	end

	// array write ports
	wire wr_commit = (state_r == S_WR_WAIT) && (timer_r == '0);
	wire wr_step   = (state_r == S_WR_ERASE) || wr_commit;
	wire ce_step   = (state_r == S_CE_SWEEP);
	wire code_we   = clk_en & ((wr_step & job_code_r) | ce_step);
	wire data_we   = clk_en & ((wr_step & ~job_code_r) | ce_step);
	wire [12:0] code_wa = ce_step ? sweep_r : job_addr_r;
	wire [10:0] data_wa = ce_step ? sweep_r[10:0] : job_addr_r[10:0];
	wire [7:0]  wr_val  = wr_commit ? job_data_r : `ISP_ERASED;

	// nonvolatile arrays, no reset
	always_ff @(posedge sys_clk)
	begin
		if (code_we)
			code_mem[code_wa] <= wr_val;
		if (data_we)
			data_mem[data_wa] <= wr_val;
	end

	// status outputs
	assign prog_mode   = prog_mode_r;
	assign isp_busy    = busy_r;
	assign cmd_overrun = overrun_r;

	// helper: cycles spent in one write
	logic [23:0] wr_len_r;
	always_ff @(posedge sys_clk)
	begin
		if (reset || state_r == S_IDLE)
			wr_len_r <= '0;
		else if (clk_en && !erasing)
			wr_len_r <= wr_len_r + 24'h000001;
	end

	// checks
	property p_fuse_enable;
		@(posedge sys_clk) disable iff (reset)
		(pop && op == OP_ENABLE && session) |=> prog_en_r;
	endproperty
	a_fuse_enable: assert property (p_fuse_enable) else $error("enable not taken");

	property p_sig_read;
		@(posedge sys_clk) disable iff (reset)
		(hdr_evt && !erasing && sig_low && rd_op == OP_RD_CODE && rd_caddr == `ISP_SIG_ADDR0)
			|=> rd_byte_r == SIG_BYTE0;
	endproperty
	a_sig_read: assert property (p_sig_read) else $error("identity byte wrong");

	property p_wr_len;
		@(posedge sys_clk) disable iff (reset)
		(state_r == S_WR_WAIT) |-> wr_len_r <= 24'(WRITE_CYCLES);
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("write overran its time");

	property p_need_enable;
		@(posedge sys_clk) disable iff (reset)
		(state_r == S_IDLE && state_nxt != S_IDLE) |-> prog_en_r;
	endproperty
	a_need_enable: assert property (p_need_enable) else $error("program without enable");

	property p_pre_erase;
		@(posedge sys_clk) disable iff (reset)
		(state_r == S_WR_ERASE && clk_en) |-> (code_we | data_we) && wr_val == `ISP_ERASED
			##1 (state_r == S_WR_WAIT);
	endproperty
	a_pre_erase: assert property (p_pre_erase) else $error("no pre-erase");

	property p_ce_sweep;
		@(posedge sys_clk) disable iff (reset)
		(ce_step && clk_en) |-> code_we && data_we && wr_val == `ISP_ERASED;
	endproperty
	a_ce_sweep: assert property (p_ce_sweep) else $error("erase sweep wrong");

	property p_leave_mode;
		@(posedge sys_clk) disable iff (reset)
		(!session && clk_en) |=> !prog_en_r && !prog_mode_r;
	endproperty
	a_leave_mode: assert property (p_leave_mode) else $error("mode kept after reset pin");

	property p_frame_len;
		@(posedge spi_sck) disable iff (link_clr_r)
		bit_cnt_r <= `ISP_FRAME_LAST;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame counter past 24");

	property p_ce_end;
		@(posedge sys_clk) disable iff (reset)
		(state_r == S_CE_WAIT && timer_r == '0 && clk_en) |=> state_r == S_IDLE && !busy_r;
	endproperty
	a_ce_end: assert property (p_ce_end) else $error("erase did not end");

	property p_erase_blank;
		@(posedge sys_clk) disable iff (reset)
		(hdr_evt && erasing) |=> rd_byte_r == `ISP_READ_BLANK;
	endproperty
	a_erase_blank: assert property (p_erase_blank) else $error("read during erase not zero");

	property p_undef;
		@(posedge sys_clk) disable iff (reset)
		(pop && op == OP_NONE) |=> state_r == S_IDLE;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined instruction acted");
endmodule

// ===== src/isp_defs.svh
// constants for the serial in-system programming block
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// system clock period in ns
`define ISP_CLK_PERIOD_NS 8
// self-timed durations in ns
`define ISP_WRITE_TIME_NS 2500000
`define ISP_ERASE_TIME_NS 16000000

// serial fuse state as shipped
`define ISP_FUSE_SHIPPED 1'b1

// frame layout, bit counter values
`define ISP_FRAME_BITS 24
`define ISP_HDR_LAST 5'h0F
`define ISP_DATA_FIRST 5'h10
`define ISP_FRAME_LAST 5'h17

// first byte of the admin instructions and their keys
`define ISP_OPC_ADMIN 8'hA4
`define ISP_KEY_ENABLE 8'h5A
`define ISP_KEY_ERASE 8'hE0

// op field in the low three bits of byte one
`define ISP_OP_RD_CODE 3'h1
`define ISP_OP_WR_CODE 3'h2
`define ISP_OP_RD_DATA 3'h5
`define ISP_OP_WR_DATA 3'h6

// array limits and identity locations
`define ISP_CODE_TOP 13'h1FFF
`define ISP_DATA_TOP 11'h7FF
`define ISP_SIG_ADDR0 13'h0030
`define ISP_SIG_ADDR1 13'h0031

// byte values
`define ISP_ERASED 8'hFF
`define ISP_READ_BLANK 8'h00

`endif

// ===== src/isp_pkg.sv
// types shared by the serial programming block
package isp_pkg;

	// sequencer states
	typedef enum logic [2:0] {
		S_IDLE,
		S_WR_ERASE,
		S_WR_WAIT,
		S_CE_SWEEP,
		S_CE_WAIT
	} isp_state_t;

	// decoded instruction kinds
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ENABLE,
		OP_ERASE,
		OP_RD_CODE,
		OP_WR_CODE,
		OP_RD_DATA,
		OP_WR_DATA
	} isp_op_t;

endpackage

// ===== src/isp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module isp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
)(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	// depth must be a power of two, at least two
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("fifo depth must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];  // storage
	logic [AW-1:0]    wr_ptr_r;     // next write slot
	logic [AW-1:0]    rd_ptr_r;     // next read slot
	logic [AW:0]      count_r;      // words held

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	// storage write
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	// pointers and count
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + AW'(1);
			if (pop)
				rd_ptr_r <= rd_ptr_r + AW'(1);
			if (push & ~pop)
				count_r <= count_r + (AW+1)'(1);
			else if (pop & ~push)
				count_r <= count_r - (AW+1)'(1);
		end
	end
endmodule

// ===== verification/isp_host.sv
// programmer model: drives the serial link frame by frame
`timescale 1ns/100ps
module isp_host (
	// serial link
	output logic      spi_sck,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	localparam int HALF = 80;  // half of the 160 ns link period

	// link clock idles low outside frames; data line starts low
	initial
	begin
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
	end

	// one three-byte frame, msb first; read byte caught on rises 17..24
	task automatic xfer(input logic [23:0] frm, output logic [7:0] rd);
		#3;  // skew off the system clock edges
		for (int i = 0; i < 24; i++)
		begin
			spi_mosi = frm[23-i];
			#HALF spi_sck = 1'b1;
			if (i >= 16)
				rd[23-i] = spi_miso;
			#HALF spi_sck = 1'b0;
		end
		spi_mosi = ~spi_mosi;  // released line shows no stale bit
		#HALF;
	endtask
endmodule

// ===== verification/serial_isp_programmer_test.sv
// self-checking bench for the serial programming engine
`timescale 1ns/100ps
`define CHK(nm, ex, gt) check(nm, 16'(ex), 16'(gt))
module serial_isp_programmer_test;
	import isp_pkg::*;
	localparam int WR_CYC = 20;    // shortened write time
	localparam int ER_CYC = 8200;  // shortened erase time

	logic       sys_clk = 1'b0;  // 125 MHz
	logic       reset   = 1'b1;  // synchronous reset
	logic       pin_rst = 1'b0;  // device reset pin
	logic       sel_a   = 1'b1;  // identity select a
	logic       sel_b   = 1'b1;  // identity select b
	logic       clk_en  = 1'b1;  // clock enable
	logic       clk_run = 1'b1;  // oscillator running
	wire        spi_sck;         // link clock
	wire        spi_mosi;        // link data in
	logic       spi_miso;        // link data out
	logic       prog_mode;       // session flag
	logic       isp_busy;        // write or erase running
	logic       cmd_overrun;     // lost frame flag
	logic [7:0] rd_v;            // last read byte
	int         n_errors = 0;    // mismatches
	int         checks_done = 0; // comparisons
	int         busy_cnt = 0;    // cycles busy seen
	int         seed = 81;       // fixed seed
	logic [12:0] ad [4];         // random addresses
	logic [7:0]  dv [4];         // random data

	// clock, held low while the oscillator is stopped
	always #4 sys_clk = clk_run ? ~sys_clk : 1'b0;

	// busy cycle counter, sampled where busy is settled
	always @(negedge sys_clk)
		if (isp_busy === 1'b1)
			busy_cnt++;

	isp_prog #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) dut_u (
		.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.isp_reset_pin(pin_rst), .signature_select_pin_a(sel_a),
		.signature_select_pin_b(sel_b), .prog_mode(prog_mode),
		.isp_busy(isp_busy), .cmd_overrun(cmd_overrun)
	);

	isp_host host_u (
		.spi_sck(spi_sck),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso)
	);

	// frame builders
	function automatic logic [23:0] fr(input logic [2:0] op, input logic [12:0] a, input logic [7:0] d);
		return {a[12:8], op, a[7:0], d};
	endfunction

	function automatic logic [2:0] rop(input logic dat);
		return dat ? 3'h5 : 3'h1;
	endfunction

	// compare and count
	task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] gt);
		checks_done++;
		if (gt !== ex)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, gt);
		end
	endtask

	task automatic send(input logic [23:0] f);
		host_u.xfer(f, rd_v);
	endtask

	// wait for busy to end, bounded
	task automatic wait_idle(input int lim);
		int k;
		repeat (20) @(negedge sys_clk);
		for (k = 0; k < lim && isp_busy !== 1'b0; k++)
			@(negedge sys_clk);
		if (k >= lim)
			`CHK("busy_end", 1'b0, isp_busy);
	endtask

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog
	initial
	begin
		#400000;  // about twice the expected run of some 230 us
		n_errors++;
		stop_test();
	end

	// main sequence
	initial
	begin
		repeat (16) @(negedge sys_clk);
		reset = 1'b0;
		`CHK("mode_idle", 1'b0, prog_mode);
		pin_rst = 1'b1;  // held high for the whole session
		repeat (12) @(negedge sys_clk);  // settle before the first frame
		`CHK("mode_on", 1'b1, prog_mode);
		tend("session");
		busy_cnt = 0;
		send(fr(3'h2, 13'h0010, 8'h55));
		send({8'hA4, 8'hE0, 8'h00});
		repeat (30) @(negedge sys_clk);
		`CHK("no_op_before_enable", 0, busy_cnt);
		tend("locked");
		send({8'hA4, 8'h5A, 8'h00});
		busy_cnt = 0;
		send({8'hA4, 8'hE0, 8'h00});
		send(fr(3'h1, 13'h1FFF, 8'h00));
		`CHK("read_in_erase", 8'h00, rd_v);
		wait_idle(ER_CYC + 100);
		`CHK("erase_time", 1'b1, busy_cnt >= ER_CYC && busy_cnt <= ER_CYC + 2);
		foreach (ad[i])
		begin
			send(fr(rop(i[0]), i[1] ? 13'h0000 : (i[0] ? 13'h07FF : 13'h1FFF), 8'h00));
			`CHK("erased", 8'hFF, rd_v);
		end
		tend("erase");
		foreach (ad[i])
		begin
			ad[i] = 13'($random(seed)) & (i[0] ? 13'h07FF : 13'h1FFF);
			dv[i] = 8'($random(seed));
			busy_cnt = 0;
			send(fr(i[0] ? 3'h6 : 3'h2, ad[i], dv[i]));
			wait_idle(WR_CYC + 100);
			`CHK("write_time", 1'b1, busy_cnt >= WR_CYC && busy_cnt <= WR_CYC + 2);
		end
		foreach (ad[i])
		begin
			send(fr(rop(i[0]), ad[i], 8'h00));
			`CHK("readback", dv[i], rd_v);
		end
		tend("random");
		busy_cnt = 0;
		send(fr(3'h2, 13'h0123, 8'hF0));
		@(negedge sys_clk);
		clk_en = 1'b0;  // freeze the running write
		repeat (10) @(negedge sys_clk);
		clk_en = 1'b1;
		wait_idle(WR_CYC + 100);
		`CHK("freeze_time", 1'b1, busy_cnt >= WR_CYC + 10 && busy_cnt <= WR_CYC + 12);
		send(fr(3'h6, 13'h0123, 8'h3C));
		wait_idle(WR_CYC + 100);
		send(fr(3'h2, 13'h0123, 8'h0F));
		wait_idle(WR_CYC + 100);
		send(fr(3'h1, 13'h0123, 8'h00));
		`CHK("pre_erase", 8'h0F, rd_v);
		send(fr(3'h5, 13'h0123, 8'h00));
		`CHK("separate_space", 8'h3C, rd_v);
		busy_cnt = 0;
		send(fr(3'h3, 13'h0123, 8'hAA));
		send({8'hA4, 8'h11, 8'h00});
		repeat (30) @(negedge sys_clk);
		`CHK("undefined_idle", 0, busy_cnt);
		send(fr(3'h1, 13'h0123, 8'h00));
		`CHK("undefined_keep", 8'h0F, rd_v);
		tend("corners");
		@(negedge sys_clk);
		sel_a = 1'b0;
		sel_b = 1'b0;
		repeat (6) @(negedge sys_clk);
		send(fr(3'h1, 13'h0030, 8'h00));
		`CHK("ident0", 8'h5C, rd_v);
		send(fr(3'h1, 13'h0031, 8'h00));
		`CHK("ident1", 8'h3D, rd_v);
		@(negedge sys_clk);
		sel_a = 1'b1;
		sel_b = 1'b1;
		tend("identity");
		send({8'hA4, 8'hE0, 8'h00});
		for (int i = 0; i < 12; i++)
			send(fr(3'h2, 13'(i), 8'(i)));
		`CHK("overrun_set", 1'b1, cmd_overrun);
		@(negedge sys_clk);
		clk_run = 1'b0;  // oscillator stopped first
		#37;
		pin_rst = 1'b0;  // then end of session
		#37;
		clk_run = 1'b1;
		repeat (12) @(negedge sys_clk);
		`CHK("mode_off", 1'b0, prog_mode);
		`CHK("overrun_clr", 1'b0, cmd_overrun);
		tend("overrun");
		stop_test();
	end
endmodule
